// File: core/sbf_funnel_dram.sv
// Purpose: byte funnel counter, lane selects, DRAM strobes and refresh
// Assumes: all strobes synchronous to pclk; delay taps modelled by flops
// Notes:   DRAM pin outputs are registered, one cycle behind their causes
`timescale 1ns/10ps
module sbf_funnel_dram
   import sbf_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        buffer_grant,
   input  wire logic        host_access_strobe_n,
   input  wire logic        control_cycle_strobe_n,
   input  wire logic        counter_load_n,
   input  wire logic        counter_write_strobe_n,
   input  wire logic        controller_chip_select_n,
   input  wire logic        controller_read_strobe_n,
   input  wire logic        controller_write_strobe_n,
   input  wire logic        byte_word_select,
   input  wire logic        read_write_latched,
   input  wire logic        ram_write_strobe_n,
   input  wire logic        latched_addr_bit0,
   input  wire logic        latched_addr_bit1,
   input  wire logic        refresh_permit_strobe_n,
   input  wire logic        refresh_base_clock,
   output logic             counter_clock,
   output logic             lane_count_low,
   output logic             lane_count_high,
   output logic      [3:0]  lane_select_n,
   output sbf_dram_s        dram,
   output logic             refresh_done,
   output logic             refresh_request_bank0,
   output logic             refresh_request_bank1,
   output logic             refresh_request_main,
   output logic             refresh_clock
);
   localparam int MUX_D = TAP_MUX_CYC + 1;

   logic                   direct_buffer_mode;
   logic                   buf_cyc;
   logic                   host_cyc;
   logic                   permit;
   logic                   ctl_cyc;
   logic                   load;
   logic                   ram_cyc;
   sbf_taps_s              taps;
   logic                   late_q_reg;
   logic                   late_rise;
   logic                   late_fall;
   logic                   phase_reg;
   logic                   wrap;
   logic                   counter_access;
   logic [1:0]             lane_idx;
   logic [31:0]            control_reg;
   logic [XFER_BITS-1:0]   xfer_count_reg;
   logic [REFCLK_BITS-1:0] ref_cnt_reg;
   logic                   base_q_reg;
   logic                   refclk_q_reg;
   logic                   refclk_rise;
   logic                   refclk_fall;
   sbf_refresh_e           rf_state_reg;
   sbf_refresh_e           rf_state_next;
   logic                   missed_reg;
   logic                   pend;
   logic                   req0;
   logic                   req1;
   logic                   host_refresh;
   logic                   rf_event;
   logic [1:0]             ras;
   logic [3:0]             cas;
   logic [3:0]             we_n_next;
   logic                   oe_n_next;
   logic [3:0]             sel_n_next;
   logic                   apb_hit;

   // strobe decode, inputs taken as synchronous
   assign direct_buffer_mode = buffer_grant;
   assign host_cyc = ~host_access_strobe_n;
   // permit strobe low means refresh now
   assign permit   = ~refresh_permit_strobe_n;
   assign ctl_cyc  = ~control_cycle_strobe_n;
   // load taken as a level over the whole control cycle
   assign load     = ~counter_load_n;
   // either controller strobe low marks a buffer cycle
   assign buf_cyc  = ~controller_read_strobe_n | ~controller_write_strobe_n;
   assign counter_access = ctl_cyc & load;
   // buffer cycle in buffer mode, else host strobe or permit, starts the delay line
   assign ram_cyc  = direct_buffer_mode ? buf_cyc : (host_cyc | permit);

   sbf_tap_line #(
      .DEPTH (TAP_LATE_CYC),
      .MUX   (TAP_MUX_CYC),
      .EARLY (TAP_EARLY_CYC),
      .LATE  (TAP_LATE_CYC)
   ) u_taps (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (ram_cyc),
      .taps    (taps)
   );

   // late tap edges as single-cycle pulses
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         late_q_reg <= 1'b0;
      else
         late_q_reg <= taps.late;
   end
   assign late_rise = taps.late & ~late_q_reg;
   assign late_fall = ~taps.late & late_q_reg;

   // phase on rise, lane step on fall: eight states per word
   // clear on load in buffer mode, else hold unless accessed
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_reg       <= 1'b0;
         lane_count_high <= 1'b0;
         lane_count_low  <= 1'b0;
      end
      else if (direct_buffer_mode ? load : counter_access)
      begin
         phase_reg       <= 1'b0;
         lane_count_high <= 1'b0;
         lane_count_low  <= 1'b0;
      end
      else if (direct_buffer_mode && late_rise)
         phase_reg <= 1'b1;
      else if (direct_buffer_mode && late_fall)
      begin
         phase_reg       <= 1'b0;
         lane_count_high <= lane_count_low;
         lane_count_low  <= ~lane_count_high;
      end
   end

   // leaving the eighth state (lane 3, phase high) clocks the address
   assign wrap = direct_buffer_mode & ~load & late_fall & phase_reg
                 & lane_count_high & ~lane_count_low;

   // host load of the address counter clocks it directly
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         counter_clock <= 1'b0;
      else if (direct_buffer_mode)
         counter_clock <= wrap;
      else
         counter_clock <= counter_access & ~counter_write_strobe_n;
   end

   // gray lane count to lane index
   assign lane_idx = {lane_count_high, lane_count_high ^ lane_count_low};

   // lane selects, active low
   always_comb
   begin
      sel_n_next = 4'hf;
      if (direct_buffer_mode)
      begin
         // lane select only inside a buffer cycle
         if (buf_cyc)
            sel_n_next[lane_idx] = 1'b0;
      end
      // host reaches the controller through lane 0
      else if (!controller_chip_select_n)
         sel_n_next[0] = 1'b0;
   end

   // refresh requests from the refresh machine
   assign pend = (rf_state_reg == sbf_pend0) | (rf_state_reg == sbf_pend1);
   assign req0 = pend & (!direct_buffer_mode | missed_reg
                         | rf_state_reg == sbf_pend0);
   assign req1 = pend & (!direct_buffer_mode | missed_reg
                         | rf_state_reg == sbf_pend1);
   // host refresh starts on a request with the permit strobe
   // the early-tap stretch only counts once the refresh itself is running,
   // so the tap tail of a host access never starts a refresh
   assign host_refresh = !direct_buffer_mode
                         & (((req0 | req1) & permit)
                            | (((rf_state_reg == sbf_dorf1)
                                | (rf_state_reg == sbf_dorf0))
                               & (permit | taps.early)));

   // row and column strobes, active high here
   always_comb
   begin
      ras      = 2'b00;
      cas      = 4'h0;
      rf_event = 1'b0;
      if (direct_buffer_mode)
      begin
         // bank row from cycle strobe, lane column from late tap
         ras[lane_count_high] = buf_cyc;
         cas[lane_idx]        = taps.late;
         // refresh the idle bank under an access to the other
         if (buf_cyc && (lane_count_high ? req0 : req1) && !missed_reg)
         begin
            cas[{~lane_count_high, 1'b0}] = 1'b1;
            cas[{~lane_count_high, 1'b1}] = 1'b1;
            ras[~lane_count_high]         = taps.early;
            rf_event                      = 1'b1;
         end
      end
      else if (host_refresh)
      begin
         // stretched column strobe, row follows the early tap
         cas      = {4{permit | taps.early}};
         ras      = {2{taps.early}};
         rf_event = 1'b1;
      end
      else
      begin
         // both banks alike for host accesses
         ras = {2{host_cyc}};
         // writes use the late tap, reads the early tap
         cas = {4{read_write_latched ? taps.late : taps.early}};
      end
   end

   // write enables and output enable
   always_comb
   begin
      we_n_next = 4'hf;
      oe_n_next = 1'b0;
      // buffer mode or word access: all lanes follow write strobe
      if (direct_buffer_mode || byte_word_select)
         we_n_next = {4{ram_write_strobe_n}};
      // byte write: one addressed lane, output disabled
      else if (read_write_latched)
      begin
         oe_n_next = 1'b1;
         we_n_next[{latched_addr_bit1, latched_addr_bit0}] =
            ram_write_strobe_n;
      end
   end

   // registered DRAM pins and lane selects
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dram          <= '{ras_n: 2'b11, cas_n: 4'hf, we_n: 4'hf,
                            oe_n: 1'b1, mux_sel: 1'b0};
         lane_select_n <= 4'hf;
         refresh_done  <= 1'b0;
      end
      else
      begin
         dram.ras_n    <= ~ras;
         dram.cas_n    <= ~cas;
         dram.we_n     <= we_n_next;
         dram.oe_n     <= oe_n_next;
         // row/column select from the 20 ns tap
         dram.mux_sel  <= taps.mux;
         lane_select_n <= sel_n_next;
         // done formed like the stretched column strobe
         refresh_done  <= rf_event;
      end
   end

   // seven-bit divider on base clock rising edges
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         base_q_reg   <= 1'b0;
         ref_cnt_reg  <= '0;
         refclk_q_reg <= 1'b0;
      end
      else
      begin
         base_q_reg   <= refresh_base_clock;
         refclk_q_reg <= ref_cnt_reg[REFCLK_BITS-1];
         if (refresh_base_clock && !base_q_reg
             && control_reg[CTRL_REFRESH_EN_BIT])
            ref_cnt_reg <= ref_cnt_reg + 1'b1;
      end
   end
   assign refresh_clock = ref_cnt_reg[REFCLK_BITS-1];
   assign refclk_rise   = refresh_clock & ~refclk_q_reg;
   assign refclk_fall   = ~refresh_clock & refclk_q_reg;

   // refresh machine next state
   always_comb
   begin
      rf_state_next = rf_state_reg;
      unique case (rf_state_reg)
         sbf_done0: if (refclk_rise) rf_state_next = sbf_pend1;
         sbf_pend1: if (rf_event) rf_state_next = sbf_dorf1;
         sbf_dorf1: if (!rf_event && !taps.late) rf_state_next = sbf_done1;
         sbf_done1:
            if (refclk_fall)
               rf_state_next = direct_buffer_mode ? sbf_pend0 : sbf_done0;
         sbf_pend0: if (rf_event) rf_state_next = sbf_dorf0;
         sbf_dorf0: if (!rf_event && !taps.late) rf_state_next = sbf_done0;
         default:   rf_state_next = sbf_done0;
      endcase
   end

   // refresh state and missed-access throttle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rf_state_reg         <= sbf_done0;
         missed_reg           <= 1'b0;
         refresh_request_main <= 1'b0;
      end
      else
      begin
         rf_state_reg <= rf_state_next;
         // a refresh clock edge while still pending means no accesses
         if (!pend)
            missed_reg <= 1'b0;
         else if (direct_buffer_mode && (refclk_rise || refclk_fall))
            missed_reg <= 1'b1;
         refresh_request_main <= pend & (!direct_buffer_mode | missed_reg)
                                 & ~rf_event;
      end
   end
   assign refresh_request_bank0 = req0;
   assign refresh_request_bank1 = req1;

   // apb slave: zero wait, read data captured in the setup cycle
   assign apb_hit = (paddr == REG_CONTROL) | (paddr == REG_STATUS)
                    | (paddr == REG_XFER_COUNT);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~apb_hit;

   // control register and transfer counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         control_reg    <= CTRL_RESET;
         xfer_count_reg <= '0;
      end
      else
      begin
         if (psel && penable && pwrite && paddr == REG_CONTROL)
            control_reg <= pwdata & CTRL_RESET;
         // a clear and a word in the same cycle keeps the word
         if (psel && penable && pwrite && paddr == REG_XFER_COUNT)
            xfer_count_reg <= {{(XFER_BITS-1){1'b0}}, wrap};
         else if (wrap)
            xfer_count_reg <= xfer_count_reg + 1'b1;
      end
   end

   // read data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= '0;
      else if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            REG_CONTROL:    prdata <= control_reg;
            REG_STATUS:     prdata <= {24'h00_0000, missed_reg,
                                       rf_state_reg, buffer_grant,
                                       phase_reg, lane_count_high,
                                       lane_count_low};
            REG_XFER_COUNT: prdata <= {16'h0000, xfer_count_reg};
            default:        prdata <= '0;
         endcase
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_last_state;
      direct_buffer_mode && !load && phase_reg && lane_count_high
      && !lane_count_low;
   endsequence
   sequence s_leave;
      direct_buffer_mode && !load && late_fall;
   endsequence

   a_lane_onehot: assert property (
      direct_buffer_mode && buf_cyc |=> $countones(~lane_select_n) == 1)
      else $error("lane select not one-hot in buffer cycle");
   a_lane_gated: assert property (
      direct_buffer_mode && !buf_cyc |=> lane_select_n == 4'hf)
      else $error("lane select active outside buffer cycle");
   a_host_lane0: assert property (
      !direct_buffer_mode && !controller_chip_select_n
      |=> lane_select_n == 4'he)
      else $error("lane 0 not selected for controller access");
   a_host_strobes: assert property (
      !direct_buffer_mode && !pend && host_cyc
      |=> dram.ras_n == 2'b00 && (dram.cas_n == 4'h0 || dram.cas_n == 4'hf))
      else $error("host access strobes differ");
   a_byte_write: assert property (
      !direct_buffer_mode && !byte_word_select && read_write_latched
      && !ram_write_strobe_n
      |=> dram.oe_n && $countones(~dram.we_n) == 1)
      else $error("byte write lane enable wrong");
   a_funnel_hold: assert property (
      !direct_buffer_mode && !counter_access
      |=> $stable({phase_reg, lane_count_high, lane_count_low}))
      else $error("funnel state moved outside buffer mode");
   a_host_clock: assert property (
      !direct_buffer_mode
      |=> counter_clock == $past(counter_access && !counter_write_strobe_n))
      else $error("counter clock wrong in host mode");
   a_word_wrap: assert property (
      (s_last_state and s_leave) |=> counter_clock ##1 !counter_clock)
      else $error("counter clock missing at last funnel state");
   a_refclk_div: assert property (
      $rose(refresh_clock) |-> $past(ref_cnt_reg[REFCLK_BITS-2:0]) == 6'h3f)
      else $error("refresh clock edge off the divider count");
   a_mux_tap: assert property (
      $rose(ram_cyc) |-> ##MUX_D dram.mux_sel)
      else $error("row/column select not from 20 ns tap");
endmodule

// File: core/sbf_pkg.sv
// Purpose: shared constants and types for the buffer funnel and DRAM control
// Assumes: pclk at 250 MHz; strobes from the outside are synchronous to it
// Notes:   all times are given in ns; the mux, early and late tap delays are turned into cycle counts here
package sbf_pkg;
   // clock and delay-line timing
   localparam int CLK_PERIOD_NS  = 4;
   localparam int TAP_STEP_NS    = 10;
   localparam int TAP_MUX_NS     = 20;
   localparam int TAP_EARLY_NS   = 40;
   localparam int TAP_LATE_NS    = 50;
   localparam int HOST_STROBE_NS = 125;
   // least delays round up to whole cycles
   localparam int TAP_MUX_CYC   = (TAP_MUX_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int TAP_EARLY_CYC = (TAP_EARLY_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int TAP_LATE_CYC  = (TAP_LATE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   // refresh clock: seven-bit divider of the 8 MHz base
   localparam int REFCLK_BITS   = 7;
   // apb register map
   localparam logic [7:0] REG_CONTROL    = 8'h00;
   localparam logic [7:0] REG_STATUS     = 8'h04;
   localparam logic [7:0] REG_XFER_COUNT = 8'h08;
   localparam int         CTRL_REFRESH_EN_BIT = 0;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
   localparam int         XFER_BITS      = 16;
   // refresh machine, gray along done0..dorf0
   typedef enum logic [2:0]
   {
      sbf_done0 = 3'b000,
      sbf_pend1 = 3'b001,
      sbf_dorf1 = 3'b011,
      sbf_done1 = 3'b010,
      sbf_pend0 = 3'b110,
      sbf_dorf0 = 3'b111
   } sbf_refresh_e;
   // delay-line taps
   typedef struct packed
   {
      logic mux;
      logic early;
      logic late;
   } sbf_taps_s;
   // DRAM control pins, all strobes active low
   typedef struct packed
   {
      logic [1:0] ras_n;
      logic [3:0] cas_n;
      logic [3:0] we_n;
      logic       oe_n;
      logic       mux_sel;
   } sbf_dram_s;
endpackage

// File: core/sbf_tap_line.sv
// Purpose: delay line giving row/column select, early and late taps
// Assumes: din is synchronous to pclk
// Notes:   each tap is a flop of one shift register, so taps are glitch free
`timescale 1ns/10ps
module sbf_tap_line
   import sbf_pkg::*;
#(
   parameter int DEPTH = TAP_LATE_CYC,
   parameter int MUX   = TAP_MUX_CYC,
   parameter int EARLY = TAP_EARLY_CYC,
   parameter int LATE  = TAP_LATE_CYC
)
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   output sbf_taps_s taps
);
   logic [DEPTH-1:0] line_reg;

   // shift the cycle strobe one stage per clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         line_reg <= '0;
      else
         line_reg <= {line_reg[DEPTH-2:0], din};
   end

   assign taps.mux   = line_reg[MUX-1];
   assign taps.early = line_reg[EARLY-1];
   assign taps.late  = line_reg[LATE-1];
endmodule

// File: test/sbf_ctrl_model.sv
// Purpose: bus controller model making buffer read and write strobes
// Assumes: go is a one-cycle request, wr is held with it
// Notes:   a strobe stands 20 cycles, long enough for the late tap
`timescale 1ns/10ps
module sbf_ctrl_model
(
   input  wire logic pclk,
   input  wire logic go,
   input  wire logic wr,
   output logic      controller_read_strobe_n,
   output logic      controller_write_strobe_n
);
   int   cnt = 0;
   logic wr_reg = 0;
   // strobe length counter
   always @(posedge pclk)
   begin
      if (go)
      begin
         cnt <= 20;
         wr_reg <= wr;
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   assign controller_write_strobe_n = !(cnt > 0 && wr_reg);
   assign controller_read_strobe_n  = !(cnt > 0 && !wr_reg);
endmodule

// File: test/sbf_funnel_dram_bench.sv
// Purpose: self-checking bench for the funnel and DRAM strobe block
// Assumes: 250 MHz pclk; the controller model makes buffer strobes
// Notes:   expectations come from lane order and package tap counts
`timescale 1ns/10ps
module sbf_funnel_dram_bench;
   import sbf_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, wv;
   logic        pready, pslverr, se, go = 0, gw = 0, bg = 0, ccs_n = 1;
   logic        has_n = 1, ccy_n = 1, cld_n = 1, cws_n = 1, bws = 0;
   logic        rwl = 0, rws_n = 1, a0 = 0, a1 = 0, rbc = 0, cr_n, cw_n;
   logic        cck, lcl, lch, prs_n = 1, rdn, rq0, rq1, rqm, rck;
   logic [3:0]  ls_n;
   sbf_dram_s   dram;
   int          err_total = 0, n_checks = 0, seed = 37, ccnt = 0, k;
   sbf_ctrl_model i_sbf_ctrl_model (.pclk(pclk), .go(go), .wr(gw),
      .controller_read_strobe_n(cr_n), .controller_write_strobe_n(cw_n));
   sbf_funnel_dram i_sbf_funnel_dram (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .buffer_grant(bg), .host_access_strobe_n(has_n),
      .control_cycle_strobe_n(ccy_n), .counter_load_n(cld_n),
      .counter_write_strobe_n(cws_n), .controller_chip_select_n(ccs_n),
      .controller_read_strobe_n(cr_n), .controller_write_strobe_n(cw_n),
      .byte_word_select(bws), .read_write_latched(rwl),
      .ram_write_strobe_n(rws_n), .latched_addr_bit0(a0),
      .latched_addr_bit1(a1), .refresh_permit_strobe_n(prs_n),
      .refresh_base_clock(rbc), .counter_clock(cck), .lane_count_low(lcl),
      .lane_count_high(lch), .lane_select_n(ls_n), .dram(dram),
      .refresh_done(rdn), .refresh_request_bank0(rq0),
      .refresh_request_bank1(rq1), .refresh_request_main(rqm),
      .refresh_clock(rck));
   // clocks: 4 ns system, 125 ns refresh base
   always #2 pclk = ~pclk;
   always #62.5 rbc = ~rbc;
   // count buffer-mode address counter pulses
   always @(posedge pclk)
      if (cck === 1'b1 && bg)
         ccnt++;
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one apb transfer, waits for pready under a bound
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      i = 0;
      do
      begin
         @(posedge pclk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      // a missing ready counts once and the run goes on to the verdict
      if (pready !== 1'b1)
         err_total++;
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // host access of 33 cycles (132 ns), timing strobes from its start
   task host_acc(input logic w, input logic word, input int ln);
      int n, tr, tm, tc;
      logic [3:0] ew;
      tr = 0;
      tm = 0;
      tc = 0;
      ew = (word | !w) ? {4{!w}} : ~(4'h1 << ln);
      @(posedge pclk);
      has_n <= 0;
      rwl <= w;
      bws <= word;
      rws_n <= !w;
      {a1, a0} <= ln[1:0];
      for (n = 1; n <= 32; n++)
      begin
         @(posedge pclk);
         #1;
         if (tr == 0 && dram.ras_n[0] === 1'b0) tr = n;
         if (tm == 0 && dram.mux_sel === 1'b1) tm = n;
         if (tc == 0 && dram.cas_n[0] === 1'b0) tc = n;
         if (n == 20)
         begin
            chk(dram.ras_n, 0);
            chk(dram.cas_n, 0);
            chk({dram.oe_n, dram.we_n}, {!word & w, ew});
         end
      end
      chk(tr, 1);
      chk(tm, TAP_MUX_CYC + 1);
      chk(tc, (w ? TAP_LATE_CYC : TAP_EARLY_CYC) + 1);
      @(posedge pclk);
      has_n <= 1;
      rws_n <= 1;
      repeat (20) @(posedge pclk);
   endtask
   // one buffer-mode byte transfer on the expected lane
   task buf_xfer(input logic w, input int ln);
      int n, tr, tc, g;
      tr = 0;
      tc = 0;
      g = (ln + 1) % 4;
      @(posedge pclk);
      go <= 1;
      gw <= w;
      @(posedge pclk);
      go <= 0;
      for (n = 1; n <= 48; n++)
      begin
         @(posedge pclk);
         #1;
         if (tr == 0 && dram.ras_n !== 2'b11) tr = n;
         if (tc == 0 && dram.cas_n !== 4'hf) tc = n;
         if (n == 16)
         begin
            chk(ls_n, 4'(~(4'h1 << ln)));
            chk(dram.ras_n, 2'(~(2'h1 << ln[1])));
            chk(dram.cas_n, 4'(~(4'h1 << ln)));
         end
      end
      chk(tc - tr, TAP_LATE_CYC);
      chk(ls_n, 4'hf);
      chk({lch, lcl}, g ^ (g >> 1));
   endtask
   // main sequence
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      #1 chk(dram, 12'hffe);
      apb(0, REG_CONTROL, 0);
      chk(rd, CTRL_RESET);
      wv = $random(seed);
      apb(1, REG_CONTROL, wv);
      apb(0, REG_CONTROL, 0);
      chk(rd, wv & 1);
      apb(0, 8'h0c, 0);
      chk(se, 1);
      chk(rd, 0);
      $display("test registers done");
      for (k = 0; k < 4; k++)
         host_acc(1, 0, k);
      host_acc(1, 1, 0);
      host_acc(0, 1, 0);
      host_acc(1, 0, $random(seed) & 3);
      host_acc(0, 0, $random(seed) & 3);
      $display("test host access done");
      @(posedge pclk);
      {ccy_n, cld_n} <= 2'b00;
      repeat (3) @(posedge pclk);
      #1 chk(cck, 0);
      @(posedge pclk);
      cws_n <= 0;
      repeat (2) @(posedge pclk);
      #1 chk({cck, lch, lcl}, 3'b100);
      @(posedge pclk);
      {ccy_n, cld_n, cws_n, ccs_n} <= 4'b1110;
      repeat (2) @(posedge pclk);
      #1 chk(ls_n, 4'he);
      @(posedge pclk);
      ccs_n <= 1;
      bg <= 1;
      $display("test counter done");
      for (k = 0; k < 4; k++)
         buf_xfer(k[0], k);
      chk(ccnt, 1);
      apb(0, REG_XFER_COUNT, 0);
      chk(rd, 1);
      $display("test buffer done");
      // host refresh: wait for the request, then grant one permit state
      @(posedge pclk);
      bg <= 0;
      apb(1, REG_CONTROL, CTRL_RESET);
      k = 0;
      while (rq0 !== 1'b1 && k < 3000)
      begin
         @(posedge pclk);
         k++;
      end
      chk({rck, rq0, rq1}, 3'h7);
      @(posedge pclk);
      prs_n <= 0;
      #1 chk(rqm, 1);
      repeat (2) @(posedge pclk);
      #1 chk({dram.ras_n, dram.cas_n, rdn}, 7'h61);
      repeat (12) @(posedge pclk);
      #1 chk({dram.ras_n, dram.cas_n}, 6'h00);
      repeat (18) @(posedge pclk);
      prs_n <= 1;
      repeat (20) @(posedge pclk);
      #1 chk({rq0, rq1, rqm, rdn, dram.ras_n}, 6'h03);
      $display("test refresh done");
      conclude;
   end
endmodule
